// file: include/sbc_pkg.sv
// constants, types and helpers for the mode, power and sample delay block
// assumes a 10 MHz system clock and a 32-bit AXI4-Lite register bus
package sbc_pkg;

	// ----------------------------------------
	// sample link framing
	// ----------------------------------------
	localparam int SAMPLE_BITS      = 24;
	localparam int SLOT_CNT_W       = 5;
	localparam int SAMPLES_PER_BAND = 12;
	localparam int SUBBANDS         = 32;
	localparam int CHANNELS         = 2;
	localparam int FRAME_SAMPLES    = SAMPLES_PER_BAND * SUBBANDS * CHANNELS;
	localparam int FRAME_IDX_W      = 10;
	localparam int FRAME_CNT_W      = 16;
	localparam int DELAY_WS_PERIODS = 480;
	localparam int SLOTS_PER_WS     = 2;
	localparam int DELAY_SLOTS      = DELAY_WS_PERIODS * SLOTS_PER_WS;

	// ----------------------------------------
	// timing
	// ----------------------------------------
	localparam int ACLK_FREQ_KHZ   = 10000;
	localparam int MCLK_FREQ_KHZ   = 24576;
	localparam int RESET_HOLD_MCLK = 5;
	localparam int LP_ENTRY_MCLK   = 9;
	// least time: round up
	localparam int RESET_HOLD_CYC  =
		(RESET_HOLD_MCLK * ACLK_FREQ_KHZ + MCLK_FREQ_KHZ - 1) / MCLK_FREQ_KHZ;
	// fixed delay: round down, at least one cycle
	localparam int LP_ENTRY_RAW    = (LP_ENTRY_MCLK * ACLK_FREQ_KHZ) / MCLK_FREQ_KHZ;
	localparam int LP_ENTRY_CYC    = (LP_ENTRY_RAW < 1) ? 1 : LP_ENTRY_RAW;
	localparam int TIMER_W         = 4;

	// ----------------------------------------
	// register map
	// ----------------------------------------
	localparam int          ADDR_W       = 12;
	localparam logic [11:0] CTRL_ADDR    = 12'h000;
	localparam logic [11:0] STATUS_ADDR  = 12'h004;
	localparam logic [11:0] FRAMES_ADDR  = 12'h008;
	localparam int          CTRL_MUTE    = 0;
	localparam int          CTRL_FR_CLR  = 1;
	localparam logic [1:0]  CTRL_RESET   = 2'h0;
	localparam int          ST_DECODE    = 0;
	localparam int          ST_SLEEP     = 1;
	localparam int          ST_LOW_POWER_OPTION    = 2;
	localparam int          ST_FRAME_RDY = 3;
	localparam int          ST_CDATA     = 4;
	localparam int          ST_RES_LSB   = 8;
	localparam int          RES_W        = 5;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	localparam logic [4:0] RES_14 = 5'h0E;
	localparam logic [4:0] RES_15 = 5'h0F;
	localparam logic [4:0] RES_16 = 5'h10;
	localparam logic [4:0] RES_18 = 5'h12;

	// ----------------------------------------
	// types
	// ----------------------------------------
	typedef enum logic [1:0] {SEL_CTRL, SEL_STATUS, SEL_FRAMES, SEL_NONE} reg_sel_t;
	typedef enum logic [1:0] {PWR_RUN, PWR_SLEEP, PWR_LOW_POWER_OPTION} power_t;

	typedef struct packed {
		logic reset_pin;
		logic sleep;
		logic low_power;
		logic codec_reset;
		logic codec_dir;
		logic res_hi;
		logic res_lo;
		logic host_mode;
		logic host_clock;
		logic host_data;
		logic codec_data;
		logic bit_clock;
		logic word_select;
		logic sample_in;
		logic frame_sync;
	} pins_t;

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic reg_sel_t reg_select(input logic [11:0] addr);
		unique case (addr)
			CTRL_ADDR:   return SEL_CTRL;
			STATUS_ADDR: return SEL_STATUS;
			FRAMES_ADDR: return SEL_FRAMES;
			default:     return SEL_NONE;
		endcase
	endfunction

	function automatic logic [4:0] resolution_bits(input logic hi, input logic lo);
		unique case ({hi, lo})
			2'h0: return RES_16;
			2'h2: return RES_18;
			2'h1: return RES_14;
			default: return RES_15;
		endcase
	endfunction

endpackage

// file: include/delay_if.sv
// carrier between the core and its sample delay store
// assumes both ends run on aclk
`timescale 1ns/10ps
`default_nettype none
interface delay_if #(parameter int WIDTH = 24);
	logic             slot_strobe;
	logic             clear;
	logic [WIDTH-1:0] write_word;
	logic [WIDTH-1:0] read_word;
	modport core  (output slot_strobe, output clear, output write_word, input read_word);
	modport store (input slot_strobe, input clear, input write_word, output read_word);
endinterface
`default_nettype wire

// file: src/sample_delay_line.sv
// circular store delaying each sample slot by DEPTH slots
// assumes one strobe per sample slot from the core
`timescale 1ns/10ps
`default_nettype none
module sample_delay_line #(
	parameter int DEPTH = 960,
	parameter int WIDTH = 24
) (
	input  wire logic aclk,
	input  wire logic aresetn,
	delay_if.store    dl
);
	localparam int PTR_W = $clog2(DEPTH);
	localparam logic [PTR_W-1:0] LAST = PTR_W'(DEPTH - 1);

	logic [WIDTH-1:0] mem [DEPTH];
	logic [PTR_W-1:0] ptr_reg;
	logic [WIDTH-1:0] out_reg;
	logic             filled_reg;

	assign dl.read_word = out_reg;

	// ----------------------------------------
	// pointer and read port
	// ----------------------------------------
	// one access per slot
	always_ff @(posedge aclk) begin
		if (!aresetn || dl.clear) begin
			ptr_reg    <= '0;
			out_reg    <= '0;
			filled_reg <= 1'h0;
		end else if (dl.slot_strobe) begin
			// unwritten words read as zero until the first wrap
			out_reg <= filled_reg ? mem[ptr_reg] : '0;
			ptr_reg <= (ptr_reg == LAST) ? '0 : ptr_reg + 1'h1;
			if (ptr_reg == LAST) begin
				filled_reg <= 1'h1;
			end
		end
	end

	// data storage needs no reset; unwritten words are masked above
	always_ff @(posedge aclk) begin
		if (dl.slot_strobe) begin
			mem[ptr_reg] <= dl.write_word;
		end
	end
endmodule
`default_nettype wire

// file: src/subband_alloc_mode_power_control.sv
// mode, reset and power control with the encode-mode sample delay path
// assumes all pins are asynchronous to aclk and a 32-bit AXI4-Lite master
//
// Functional notes
// - codec reset fall latches direction: high decode
// - codec reset high resets whole device logic; code clears only sample link, delay store and frame counts, not mute
// - reset pin held five master clocks resets
// - pin reset returns device to decode
// - low-power option ignores reset pin entirely
// - sleep input stops internal clocks
// - sleep puts three-state buffers high impedance
// - sleep freezes other outputs at last value
// - low-power decode entered nine master clocks later
// - low-power decode bypasses host bus to codec
// - exit performs internal reset into decode
// - encode gathers whole frame before results
// - encode resends samples 480 word periods later
// - word period equals one sample period
// - frame is 12x32x2 samples of 24 bits
// - resolution pins choose 16, 18, 14, 15 bits
`timescale 1ns/10ps
`default_nettype none
module subband_alloc_mode_power_control #(
	parameter int DELAY_SLOTS = sbc_pkg::DELAY_SLOTS
) (
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic [11:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [11:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        hw_reset_in,
	input  wire logic        sleep_in,
	input  wire logic        low_power_option,
	input  wire logic        codec_reset_in,
	input  wire logic        codec_direction_in,
	input  wire logic        resolution_select_lo,
	input  wire logic        resolution_select_hi,
	input  wire logic        host_bus_mode,
	input  wire logic        host_bus_clock,
	input  wire logic        host_bus_data_in,
	output logic             host_bus_data_out,
	output logic             host_bus_data_oe,
	output logic             codec_bus_mode,
	output logic             codec_bus_clock,
	input  wire logic        codec_bus_data_in,
	output logic             codec_bus_data_out,
	output logic             codec_bus_data_oe,
	input  wire logic        subband_bit_clock,
	input  wire logic        subband_word_select,
	input  wire logic        subband_sample_in,
	input  wire logic        subband_frame_sync,
	output logic             subband_sample_out,
	output logic             clocks_gated
);
	localparam int SB = sbc_pkg::SAMPLE_BITS;
	localparam int TW = sbc_pkg::TIMER_W;
	localparam logic [TW-1:0] HOLD_CYC = TW'(sbc_pkg::RESET_HOLD_CYC);
	localparam logic [TW-1:0] LP_CYC   = TW'(sbc_pkg::LP_ENTRY_CYC);
	localparam logic [sbc_pkg::FRAME_IDX_W-1:0] FRAME_LAST =
		sbc_pkg::FRAME_IDX_W'(sbc_pkg::FRAME_SAMPLES - 1);
	localparam logic [sbc_pkg::SLOT_CNT_W-1:0] SLOT_FULL = '1;

	sbc_pkg::pins_t pins_in;
	sbc_pkg::pins_t sync1_reg;
	sbc_pkg::pins_t sync2_reg;
	sbc_pkg::pins_t prev_reg;
	sbc_pkg::power_t pwr_reg;
	logic [TW-1:0] hold_cnt_reg;
	logic [TW-1:0] lp_cnt_reg;
	logic          decode_reg;
	logic          pin_reset;
	logic          lp_exit;
	logic          gen_reset;
	logic          run;

	// ----------------------------------------
	// pin synchronisers
	// ----------------------------------------
	assign pins_in = '{reset_pin: hw_reset_in, sleep: sleep_in,
		low_power: low_power_option, codec_reset: codec_reset_in,
		codec_dir: codec_direction_in, res_hi: resolution_select_hi,
		res_lo: resolution_select_lo, host_mode: host_bus_mode,
		host_clock: host_bus_clock, host_data: host_bus_data_in,
		codec_data: codec_bus_data_in, bit_clock: subband_bit_clock,
		word_select: subband_word_select, sample_in: subband_sample_in,
		frame_sync: subband_frame_sync};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sync1_reg <= '0;
			sync2_reg <= '0;
			prev_reg  <= '0;
		end else begin
			sync1_reg <= pins_in;
			sync2_reg <= sync1_reg;
			prev_reg  <= sync2_reg;
		end
	end

	// ----------------------------------------
	// reset sources
	// ----------------------------------------
	// count consecutive high samples
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hold_cnt_reg <= '0;
		end else if (!sync2_reg.reset_pin || sync2_reg.low_power || sync2_reg.sleep) begin
			hold_cnt_reg <= '0;
		end else if (hold_cnt_reg != HOLD_CYC) begin
			hold_cnt_reg <= hold_cnt_reg + 1'h1;
		end
	end

	assign pin_reset = (hold_cnt_reg == HOLD_CYC) && (pwr_reg == sbc_pkg::PWR_RUN);
	assign lp_exit   = (pwr_reg == sbc_pkg::PWR_LOW_POWER_OPTION) && !sync2_reg.sleep
		&& !sync2_reg.codec_dir && sync2_reg.codec_reset;
	// codec reset is a general reset
	assign gen_reset = ((pwr_reg == sbc_pkg::PWR_RUN) && (sync2_reg.codec_reset || pin_reset))
		|| lp_exit;
	assign run       = (pwr_reg == sbc_pkg::PWR_RUN);

	// ----------------------------------------
	// power state
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pwr_reg    <= sbc_pkg::PWR_RUN;
			lp_cnt_reg <= '0;
		end else begin
			unique case (pwr_reg)
				sbc_pkg::PWR_RUN: begin
					if (sync2_reg.sleep && !sync2_reg.low_power) begin
						pwr_reg <= sbc_pkg::PWR_SLEEP;
					end else if (sync2_reg.sleep && sync2_reg.low_power) begin
						lp_cnt_reg <= lp_cnt_reg + 1'h1;
						if (lp_cnt_reg == LP_CYC - 1'h1) begin
							pwr_reg <= sbc_pkg::PWR_LOW_POWER_OPTION;
						end
					end else begin
						lp_cnt_reg <= '0;
					end
				end
				sbc_pkg::PWR_SLEEP: begin
					// host must lower sleep to leave
					if (!sync2_reg.sleep) begin
						pwr_reg <= sbc_pkg::PWR_RUN;
					end
				end
				sbc_pkg::PWR_LOW_POWER_OPTION: begin
					lp_cnt_reg <= '0;
					if (lp_exit) begin
						pwr_reg <= sbc_pkg::PWR_RUN;
					end
				end
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clocks_gated <= 1'h0;
		end else begin
			clocks_gated <= (pwr_reg != sbc_pkg::PWR_RUN);
		end
	end

	// ----------------------------------------
	// operating mode
	// ----------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			decode_reg <= 1'h1;
		// pin reset and exit come up decoding
		end else if (pin_reset || lp_exit) begin
			decode_reg <= 1'h1;
		end else if (run && prev_reg.codec_reset && !sync2_reg.codec_reset) begin
			decode_reg <= sync2_reg.codec_dir;
		end
	end

	// ----------------------------------------
	// control bus lines
	// ----------------------------------------
	// bypass passes through the synchronisers, so it adds three aclk of lag
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			codec_bus_mode     <= 1'h1;
			codec_bus_clock    <= 1'h1;
			codec_bus_data_out <= 1'h0;
			codec_bus_data_oe  <= 1'h0;
			host_bus_data_out  <= 1'h0;
			host_bus_data_oe   <= 1'h0;
		end else begin
			unique case (pwr_reg)
				sbc_pkg::PWR_LOW_POWER_OPTION: begin
					codec_bus_mode     <= sync2_reg.host_mode;
					codec_bus_clock    <= sync2_reg.host_clock;
					codec_bus_data_out <= sync2_reg.host_data;
					codec_bus_data_oe  <= 1'h1;
					host_bus_data_out  <= sync2_reg.codec_data;
					host_bus_data_oe   <= 1'h0;
				end
				sbc_pkg::PWR_SLEEP: begin
					codec_bus_data_oe <= 1'h0;
					host_bus_data_oe  <= 1'h0;
				end
				sbc_pkg::PWR_RUN: begin
					codec_bus_mode    <= 1'h1;
					codec_bus_clock   <= 1'h1;
					codec_bus_data_oe <= 1'h0;
					host_bus_data_oe  <= 1'h0;
				end
			endcase
		end
	end

	// ----------------------------------------
	// sample link
	// ----------------------------------------
	delay_if #(.WIDTH(SB)) dl ();

	sample_delay_line #(.DEPTH(DELAY_SLOTS), .WIDTH(SB)) u_delay (
		.aclk    (aclk),
		.aresetn (aresetn),
		.dl      (dl)
	);

	logic                             bit_rise;
	logic                             bit_fall;
	logic                             ws_last_reg;
	logic [sbc_pkg::SLOT_CNT_W-1:0]   bit_cnt_reg;
	logic [SB-1:0]                    rx_reg;
	logic [SB-1:0]                    tx_reg;
	logic                             load_reg;
	logic                             boundary;
	logic                             mute_reg;
	logic                             frame_clr;
	logic                             frame_rdy_reg;
	logic [sbc_pkg::FRAME_IDX_W-1:0]  frame_idx_reg;
	logic [sbc_pkg::FRAME_CNT_W-1:0]  frames_reg;

	assign bit_rise = sync2_reg.bit_clock && !prev_reg.bit_clock;
	assign bit_fall = !sync2_reg.bit_clock && prev_reg.bit_clock;
	assign boundary = run && bit_rise && (sync2_reg.word_select != ws_last_reg);

	assign dl.slot_strobe = boundary && !decode_reg;
	assign dl.clear       = gen_reset;
	assign dl.write_word  = rx_reg;

	// capture 24 msb-first bits per slot
	always_ff @(posedge aclk) begin
		if (!aresetn || gen_reset) begin
			ws_last_reg <= 1'h0;
			bit_cnt_reg <= '0;
			rx_reg      <= '0;
		end else if (run && bit_rise) begin
			ws_last_reg <= sync2_reg.word_select;
			if (boundary) begin
				bit_cnt_reg <= '0;
				rx_reg      <= '0;
			end else if (bit_cnt_reg != SLOT_FULL) begin
				bit_cnt_reg <= bit_cnt_reg + 1'h1;
				if (bit_cnt_reg < sbc_pkg::SLOT_CNT_W'(SB)) begin
					rx_reg <= {rx_reg[SB-2:0], sync2_reg.sample_in};
				end
			end
		end
	end

	// delayed word sent in the next slot
	always_ff @(posedge aclk) begin
		if (!aresetn || gen_reset) begin
			load_reg           <= 1'h0;
			tx_reg             <= '0;
			subband_sample_out <= 1'h0;
		end else if (run) begin
			load_reg <= dl.slot_strobe;
			if (load_reg) begin
				tx_reg <= mute_reg ? '0 : dl.read_word;
			end else if (bit_fall) begin
				subband_sample_out <= !decode_reg && tx_reg[SB-1];
				tx_reg             <= {tx_reg[SB-2:0], 1'h0};
			end
		end
	end

	// sync rise restarts the sample index within the frame
	always_ff @(posedge aclk) begin
		if (!aresetn || gen_reset) begin
			frame_idx_reg <= '0;
			frames_reg    <= '0;
			frame_rdy_reg <= 1'h0;
		end else begin
			if (run && sync2_reg.frame_sync && !prev_reg.frame_sync) begin
				frame_idx_reg <= '0;
			end else if (dl.slot_strobe) begin
				frame_idx_reg <= (frame_idx_reg == FRAME_LAST) ? '0 : frame_idx_reg + 1'h1;
			end
			// set wins over a software clear
			if (dl.slot_strobe && frame_idx_reg == FRAME_LAST) begin
				frame_rdy_reg <= 1'h1;
				frames_reg    <= frames_reg + 1'h1;
			end else if (frame_clr) begin
				frame_rdy_reg <= 1'h0;
			end
		end
	end

	// ----------------------------------------
	// register bus
	// ----------------------------------------
	logic [11:0] aw_addr_reg;
	logic        aw_have_reg;
	logic [31:0] w_data_reg;
	logic [3:0]  w_strb_reg;
	logic        w_have_reg;
	logic        wr_fire;
	logic [31:0] status_word;

	assign wr_fire   = aw_have_reg && w_have_reg && !s_axi_bvalid;
	assign frame_clr = wr_fire && w_strb_reg[0] && w_data_reg[sbc_pkg::CTRL_FR_CLR]
		&& (sbc_pkg::reg_select(aw_addr_reg) == sbc_pkg::SEL_CTRL);

	always_comb begin
		status_word = '0;
		status_word[sbc_pkg::ST_DECODE]    = decode_reg;
		status_word[sbc_pkg::ST_SLEEP]     = (pwr_reg == sbc_pkg::PWR_SLEEP);
		status_word[sbc_pkg::ST_LOW_POWER_OPTION]    = (pwr_reg == sbc_pkg::PWR_LOW_POWER_OPTION);
		status_word[sbc_pkg::ST_FRAME_RDY] = frame_rdy_reg;
		status_word[sbc_pkg::ST_CDATA]     = sync2_reg.codec_data;
		status_word[sbc_pkg::ST_RES_LSB +: sbc_pkg::RES_W] =
			sbc_pkg::resolution_bits(sync2_reg.res_hi, sync2_reg.res_lo);
	end

	// address and data taken in either order; response after both
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_awready <= 1'h1;
			s_axi_wready  <= 1'h1;
			s_axi_bvalid  <= 1'h0;
			s_axi_bresp   <= sbc_pkg::RESP_OKAY;
			aw_have_reg   <= 1'h0;
			w_have_reg    <= 1'h0;
			aw_addr_reg   <= '0;
			w_data_reg    <= '0;
			w_strb_reg    <= '0;
		end else begin
			if (s_axi_awready && s_axi_awvalid) begin
				aw_addr_reg   <= s_axi_awaddr;
				aw_have_reg   <= 1'h1;
				s_axi_awready <= 1'h0;
			end
			if (s_axi_wready && s_axi_wvalid) begin
				w_data_reg   <= s_axi_wdata;
				w_strb_reg   <= s_axi_wstrb;
				w_have_reg   <= 1'h1;
				s_axi_wready <= 1'h0;
			end
			if (wr_fire) begin
				s_axi_bvalid <= 1'h1;
				s_axi_bresp  <= (sbc_pkg::reg_select(aw_addr_reg) == sbc_pkg::SEL_CTRL)
					? sbc_pkg::RESP_OKAY : sbc_pkg::RESP_SLVERR;
				aw_have_reg  <= 1'h0;
				w_have_reg   <= 1'h0;
			end
			if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid  <= 1'h0;
				s_axi_awready <= 1'h1;
				s_axi_wready  <= 1'h1;
			end
		end
	end

	// mute kept across general resets so software setup survives codec resets
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mute_reg <= sbc_pkg::CTRL_RESET[sbc_pkg::CTRL_MUTE];
		end else if (wr_fire && w_strb_reg[0]
			&& sbc_pkg::reg_select(aw_addr_reg) == sbc_pkg::SEL_CTRL) begin
			mute_reg <= w_data_reg[sbc_pkg::CTRL_MUTE];
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_arready <= 1'h1;
			s_axi_rvalid  <= 1'h0;
			s_axi_rdata   <= '0;
			s_axi_rresp   <= sbc_pkg::RESP_OKAY;
		end else if (s_axi_arready && s_axi_arvalid) begin
			s_axi_arready <= 1'h0;
			s_axi_rvalid  <= 1'h1;
			s_axi_rresp   <= sbc_pkg::RESP_OKAY;
			unique case (sbc_pkg::reg_select(s_axi_araddr))
				sbc_pkg::SEL_CTRL:   s_axi_rdata <= 32'({mute_reg});
				sbc_pkg::SEL_STATUS: s_axi_rdata <= status_word;
				sbc_pkg::SEL_FRAMES: s_axi_rdata <= 32'(frames_reg);
				sbc_pkg::SEL_NONE: begin
					s_axi_rdata <= '0;
					s_axi_rresp <= sbc_pkg::RESP_SLVERR;
				end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'h0;
			s_axi_arready <= 1'h1;
		end
	end
endmodule
`default_nettype wire

// file: test/sbc_chk.sv
// port checker for the mode, power and register bus behaviour
// assumes it is bound onto the top module, one aclk domain
`timescale 1ns/10ps
`default_nettype none
module sbc_chk (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic sleep_in,
	input wire logic low_power_option,
	input wire logic host_bus_data_in,
	input wire logic host_bus_mode,
	input wire logic host_bus_clock,
	input wire logic codec_bus_mode,
	input wire logic codec_bus_clock,
	input wire logic host_bus_data_oe,
	input wire logic codec_bus_data_out,
	input wire logic codec_bus_data_oe,
	input wire logic subband_sample_out,
	input wire logic clocks_gated
);
	default clocking @(posedge aclk); endclocking
	default disable iff (!aresetn);
	logic [2:0] host_lines;
	logic [2:0] codec_lines;
	assign host_lines  = {host_bus_mode, host_bus_clock, host_bus_data_in};
	assign codec_lines = {codec_bus_mode, codec_bus_clock, codec_bus_data_out};
	chk_oe_only_lp: assert property (codec_bus_data_oe |-> clocks_gated)
		else $error("codec data driven outside low power");
	chk_host_hiz: assert property (clocks_gated |-> !host_bus_data_oe)
		else $error("host data driven while gated");
	chk_gate_entry: assert property (sleep_in [*8] |-> clocks_gated)
		else $error("clocks not gated after sleep");
	chk_lp_bypass: assert property ((sleep_in && low_power_option) [*8] |-> codec_bus_data_oe)
		else $error("no bypass in low power");
	chk_bypass_copy: assert property ((codec_bus_data_oe && $stable(host_lines)) [*6]
		|-> codec_lines == host_lines)
		else $error("bypass lines wrong");
	chk_gated_freeze: assert property (clocks_gated [*2] |-> $stable(subband_sample_out))
		else $error("sample output moved while gated");
	chk_write_resp: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
		|=> !s_axi_awready && !s_axi_wready ##1 s_axi_bvalid)
		else $error("write response late");
	chk_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
		else $error("bvalid dropped early");
	chk_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
		else $error("read response late");
	cover property (codec_bus_data_oe);
	cover property (clocks_gated && !low_power_option);
	cover property (s_axi_bvalid && s_axi_bready);
endmodule
bind subband_alloc_mode_power_control sbc_chk i_chk (.*);
`default_nettype wire

// file: test/codec_link_model.sv
// far-side codec model: bit clock, word select, samples, frame sync
// assumes run is held for whole slots; clock stands still otherwise
`timescale 1ns/10ps
`default_nettype none
module codec_link_model (
	input  wire logic run,
	input  wire logic sample_out,
	output logic      bit_clock,
	output logic      word_select,
	output logic      sample_in,
	output logic      frame_sync
);
	logic [23:0] sent_q[$];
	logic [23:0] got_q[$];
	logic [23:0] word;
	logic [23:0] rx;
	initial begin
		{bit_clock, word_select, sample_in, frame_sync} = 4'h0;
		rx = 24'h0;
		wait (run);
		// keep pin changes off the aclk edges
		#20;
		frame_sync = 1'b1;
		#800 frame_sync = 1'b0;
		while (run) begin
			word = (sent_q.size() < 2) ? 24'h0 : 24'($urandom);
			sent_q.push_back(word);
			for (int k = 0; k < 32; k++) begin
				bit_clock = 1'b0;
				if (k == 26) got_q.push_back(rx);
				if (k > 1 && k < 26) rx = {rx[22:0], sample_out};
				if (k == 0) word_select = ~word_select;
				sample_in = (k > 0 && k < 25) ? word[24-k] : 1'($urandom);
				#400 bit_clock = 1'b1;
				#400;
			end
		end
		// released line must not keep its level
		sample_in = ~sample_in;
	end
endmodule
`default_nettype wire

// file: test/subband_alloc_mode_power_control_tb.sv
// self-checking bench for mode, power and the sample delay path
// assumes the checker and link model are compiled first
`timescale 1ns/10ps
`default_nettype none
module subband_alloc_mode_power_control_tb;
	localparam int D = 8;
	localparam logic [31:0] M = 32'h00001F17;
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
	logic s_axi_rready, hw_reset_in, sleep_in, low_power_option, codec_reset_in;
	logic codec_direction_in, resolution_select_lo, resolution_select_hi, host_bus_mode;
	logic host_bus_clock, host_bus_data_in, host_bus_data_out, host_bus_data_oe;
	logic codec_bus_mode, codec_bus_clock, codec_bus_data_in, codec_bus_data_out;
	logic codec_bus_data_oe, subband_bit_clock, subband_word_select, subband_sample_in;
	logic subband_frame_sync, subband_sample_out, clocks_gated, run;
	logic [11:0] s_axi_awaddr, s_axi_araddr;
	logic [31:0] s_axi_wdata, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb;
	logic [1:0]  s_axi_bresp, s_axi_rresp, r;
	int          fails, n_checks;
	subband_alloc_mode_power_control #(.DELAY_SLOTS(D)) i_dut (.*);
	codec_link_model i_link (.run(run), .sample_out(subband_sample_out),
		.bit_clock(subband_bit_clock), .word_select(subband_word_select),
		.sample_in(subband_sample_in), .frame_sync(subband_frame_sync));
	initial aclk = 1'b0;
	always #50 aclk = ~aclk;
	always begin
		repeat (8) @(posedge aclk);
		{host_bus_mode, host_bus_clock, host_bus_data_in} <= 3'($urandom);
	end
	initial begin
		#3000000;
		fails++;
		end_sim;
	end
	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic end_sim;
		if (fails == 0 && n_checks > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("Error %0t: got %h want %h", $time, seen, exp);
		end
	endtask
	function automatic logic [4:0] res(input logic [1:0] s);
		return s == 2'h0 ? 5'h10 : s == 2'h2 ? 5'h12 : s == 2'h1 ? 5'h0E : 5'h0F;
	endfunction
	task automatic wr(input logic [11:0] a, input logic [31:0] v);
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
		forever begin
			@(posedge aclk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			if (s_axi_bvalid) break;
		end
		r = s_axi_bresp;
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a);
		@(posedge aclk);
		s_axi_araddr <= a;
		{s_axi_arvalid, s_axi_rready} <= 2'h3;
		forever begin
			@(posedge aclk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			if (s_axi_rvalid) break;
		end
		d = s_axi_rdata;
		r = s_axi_rresp;
		s_axi_rready <= 1'b0;
	endtask
	task automatic stat(input logic dec, input logic slp, input logic lp);
		codec_bus_data_in <= 1'($urandom);
		repeat (8) @(posedge aclk);
		rd(12'h004);
		check(d & M, {19'h0, res({resolution_select_hi, resolution_select_lo}), 3'h0,
			codec_bus_data_in, 1'b0, lp, slp, dec});
	endtask
	task automatic mode(input logic dir);
		codec_direction_in <= dir;
		codec_reset_in <= 1'b1;
		repeat (8) @(posedge aclk);
		codec_reset_in <= 1'b0;
	endtask
	task automatic pin_reset;
		hw_reset_in <= 1'b1;
		repeat (6) @(posedge aclk); // held long enough
		hw_reset_in <= 1'b0;
	endtask
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		void'($urandom(70372));
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = '0;
		{hw_reset_in, sleep_in, low_power_option, codec_reset_in, run, codec_bus_data_in} = '0;
		{codec_direction_in, resolution_select_lo, resolution_select_hi} = '0;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
		s_axi_wstrb = 4'hF;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 4; i++) begin
			{resolution_select_hi, resolution_select_lo} <= 2'($urandom + i);
			stat(1'b1, 1'b0, 1'b0);
		end
		rd(12'h00C);
		check({d[29:0], r}, 32'h2);
		rd(12'h008);
		check({d[29:0], r}, 32'h0);
		wr(12'h004, 32'h1);
		check({30'h0, r}, 32'h2);
		wr(12'h000, 32'h3);
		rd(12'h000);
		check({d[29:0], r}, 32'h4);
		wr(12'h000, 32'h0);
		mode(1'b0);
		stat(1'b0, 1'b0, 1'b0);
		run <= 1'b1;
		while (i_link.sent_q.size() < D + 14) @(posedge aclk);
		run <= 1'b0;
		repeat (400) @(posedge aclk);
		for (int i = 0; i < i_link.got_q.size(); i++)
			check(32'(i_link.got_q[i]), (i > D) ? 32'(i_link.sent_q[i-D-1]) : 32'h0);
		pin_reset;
		stat(1'b1, 1'b0, 1'b0);
		mode(1'b0);
		low_power_option <= 1'b1;
		pin_reset;
		stat(1'b0, 1'b0, 1'b0);
		low_power_option <= 1'b0;
		sleep_in <= 1'b1;
		stat(1'b0, 1'b1, 1'b0);
		check({clocks_gated, codec_bus_data_oe}, 32'h2);
		sleep_in <= 1'b0;
		stat(1'b0, 1'b0, 1'b0);
		mode(1'b1);
		low_power_option <= 1'b1;
		sleep_in <= 1'b1;
		pin_reset;
		stat(1'b1, 1'b0, 1'b1);
		check(32'(host_bus_data_out), 32'(codec_bus_data_in));
		repeat (16) @(posedge aclk);
		{sleep_in, codec_direction_in, codec_reset_in} <= 3'h1;
		stat(1'b1, 1'b0, 1'b0);
		check({28'h0, codec_bus_mode, codec_bus_clock, codec_bus_data_oe, clocks_gated}, 32'hC);
		end_sim;
	end
endmodule
`default_nettype wire
